//--- verification/sac_far.sv
`timescale 1ns/10ps
`default_nettype none
// =====
// far side: receiver square wave while heat is on, button level
module sac_far
(
  // clock, reset and commands
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic heat_i,
  input wire logic press_i,
  // pins toward the controller
  output logic rx_o,
  output logic btn_o
);
  // 16-cycle period, so every 10-sample window of the controller sees a one
  logic [3:0] ph_ff;
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      ph_ff <= 4'h0;
      rx_o <= 1'h0;
      btn_o <= 1'h0;
    end
    else
    begin
      ph_ff <= ph_ff + 4'h1;
      rx_o <= heat_i & ph_ff[3];
      btn_o <= press_i;
    end
  end
endmodule : sac_far
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sac_pkg::*;
  // alarm time longer than one window, so a heat loss is seen before the relay fires
  localparam int SAMP = 20, HALF = 3, POLL = 7, SEC = 60, AS = 4, RS = 2;
  logic clk_i = 1'h0, rst_b_i = 1'h0, heat = 1'h0, press = 1'h0;
  logic rx, btn, alarm_o;
  sac_out_t drive_o;
  int error_cnt = 0, n_compared = 0;
  sac_ctrl #(.SAMPLE_CYC(SAMP), .TONE_HALF_CYC(HALF), .POLL_CYC(POLL), .SEC_CYC(SEC), .ALARM_S(AS),
    .RELAY_S(RS)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .rx_i(rx), .btn_i(btn), .drive_o(drive_o),
    .alarm_o(alarm_o));
  sac_far far (.clk_i(clk_i), .rst_b_i(rst_b_i), .heat_i(heat), .press_i(press), .rx_o(rx), .btn_o(btn));
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  // =====
  // shared helpers
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  task summarize;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // sample a little after the edge so its updates have landed
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task wait_alarm(input logic v, input int bound, output int n);
    n = 0;
    // let an edge that may have just moved the alarm settle first
    #1;
    while (alarm_o !== v)
    begin
      cyc(1);
      n++;
      if (n > bound)
      begin
        chk("alarm wait timeout", 0, 1);
        summarize();
      end
    end
  endtask : wait_alarm
  // =====
  // scenarios
  task t_quiet;
    repeat (9)
    begin
      cyc(50);
      chk("quiet outputs", 0, {alarm_o, drive_o});
    end
    $display("quiet done");
  endtask : t_quiet
  task t_tone;
    int n;
    logic [2:0] p;
    @(posedge clk_i) heat <= 1'h1;
    wait_alarm(1'h1, 450, n);
    for (int k = 0; k < 3; k++)
    begin
      p = drive_o.spk;
      n = 0;
      while (drive_o.spk === p && n < 20)
      begin
        cyc(1);
        n++;
      end
      chk("spk in phase", 1, (drive_o.spk === 3'h7) || (drive_o.spk === 3'h0));
      if (k > 0) chk("tone half period", HALF, n);
    end
    $display("tone done");
  endtask : t_tone
  task t_button;
    int n;
    @(posedge clk_i) press <= 1'h1;
    wait_alarm(1'h0, POLL + 4, n);
    chk("silenced outputs", 0, drive_o);
    @(posedge clk_i) press <= 1'h0;
    $display("button done");
  endtask : t_button
  task t_heat_gone;
    int n;
    wait_alarm(1'h1, 450, n);
    @(posedge clk_i) heat <= 1'h0;
    // the cycle spent lowering heat is already one alarm cycle
    n = 1;
    while (alarm_o === 1'h1 && n < 300)
    begin
      cyc(1);
      n++;
    end
    chk("alarm after heat loss", 10 * SAMP, n);
    chk("heat loss outputs", 0, drive_o);
    $display("heat loss done");
  endtask : t_heat_gone
  task t_relay;
    int n;
    @(posedge clk_i) heat <= 1'h1;
    wait_alarm(1'h1, 450, n);
    n = 0;
    while (alarm_o === 1'h1 && n < 300)
    begin
      cyc(1);
      n++;
    end
    chk("alarm length", AS * SEC, n);
    chk("relay on", 1, drive_o.relay);
    n = 0;
    while (drive_o.relay === 1'h1 && n < 300)
    begin
      cyc(1);
      n++;
    end
    chk("relay length", RS * SEC, n);
    chk("idle after relay", 0, {alarm_o, drive_o});
    @(posedge clk_i) heat <= 1'h0;
    $display("relay done");
  endtask : t_relay
  initial
  begin
    cyc(4);
    chk("reset outputs", 0, {alarm_o, drive_o});
    @(posedge clk_i) rst_b_i <= 1'h1;
    t_quiet();
    t_tone();
    t_button();
    t_heat_gone();
    t_relay();
    summarize();
  end
endmodule : tb
`default_nettype wire

//--- verilog/sac_ctrl.sv
// What this block does
// - the receiver input is judged over ten samples taken 20 ms apart, a 200 ms window.
// - heat counts as present when any sample of the window reads one, absent otherwise.
// - the alarm sounds while heat keeps being detected.
// - the alarm tone is an 851 Hz square wave made from the system clock.
// - the same tone drives three outputs at once and in phase.
// - while the alarm sounds the button is polled every 1.702 ms.
// - the button is active high and a one reads as a press while held.
// - a press during the alarm stops the tone, clears the timers and keeps the relay off.
// - the relay output rises only after five minutes of alarm with no press.
// - the relay output stays high for two seconds and then falls.
// - every timing figure is derived from the single system clock.
`timescale 1ns/10ps
`default_nettype none
`include "sac_defs.svh"
module sac_ctrl
  import sac_pkg::*;
#(
  parameter int unsigned CLK_HZ = `SAC_CLK_HZ,
  parameter int unsigned SAMPLE_CYC = CLK_HZ / 1000 * `SAC_SAMPLE_MS,
  parameter int unsigned TONE_HALF_CYC = CLK_HZ / (2 * `SAC_TONE_HZ),
  parameter int unsigned POLL_CYC = CLK_HZ / 1000000 * `SAC_POLL_US,
  parameter int unsigned SEC_CYC = CLK_HZ,
  parameter int unsigned ALARM_S = `SAC_ALARM_S,
  parameter int unsigned RELAY_S = `SAC_RELAY_S
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // pins from receiver and button
  input wire logic rx_i,
  input wire logic btn_i,
  // speaker and relay drive
  output sac_out_t drive_o,
  output logic alarm_o
);

  // ==========================================
  // pin synchronisers
  logic [1:0] rx_sync_ff;
  logic [1:0] btn_sync_ff;
  logic rx_s;
  logic btn_s;
  assign rx_s = rx_sync_ff[1];
  assign btn_s = btn_sync_ff[1];

  // ==========================================
  // state
  sac_state_t state_ff, nxt_state;
  logic [31:0] smp_cnt_ff, nxt_smp_cnt;
  logic [3:0] smp_idx_ff, nxt_smp_idx;
  logic any_ff, nxt_any;
  logic heat_ff, nxt_heat;
  logic [31:0] tone_cnt_ff, nxt_tone_cnt;
  logic tone_ff, nxt_tone;
  logic [31:0] poll_cnt_ff, nxt_poll_cnt;
  logic [31:0] sec_div_ff, nxt_sec_div;
  logic [8:0] sec_cnt_ff, nxt_sec_cnt;
  logic relay_ff, nxt_relay;
  logic smp_tick;
  logic win_done;
  logic poll_tick;
  logic sec_tick;

  // all dividers count the one system clock
  assign smp_tick = (smp_cnt_ff == SAMPLE_CYC - 1);
  assign win_done = smp_tick && (smp_idx_ff == 4'(`SAC_SAMPLES - 1));
  assign poll_tick = (state_ff == SAC_ALARM) && (poll_cnt_ff == POLL_CYC - 1);
  assign sec_tick = (state_ff != SAC_IDLE) && (sec_div_ff == SEC_CYC - 1);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_smp_cnt = smp_tick ? 32'h0 : smp_cnt_ff + 32'h1;
    nxt_smp_idx = smp_idx_ff;
    nxt_any = any_ff;
    nxt_heat = heat_ff;
    nxt_tone_cnt = 32'h0;
    nxt_tone = 1'h0;
    nxt_poll_cnt = 32'h0;
    nxt_sec_div = 32'h0;
    nxt_sec_cnt = 9'h0;
    nxt_relay = 1'h0;
    // the window always runs so a decision is ready whenever the alarm is idle
    if (smp_tick)
    begin
      if (win_done)
      begin
        nxt_heat = any_ff | rx_s;
        nxt_any = 1'h0;
        nxt_smp_idx = 4'h0;
      end
      else
      begin
        nxt_any = any_ff | rx_s;
        nxt_smp_idx = smp_idx_ff + 4'h1;
      end
    end
    if (state_ff != SAC_IDLE)
    begin
      nxt_sec_div = sec_tick ? 32'h0 : sec_div_ff + 32'h1;
      nxt_sec_cnt = sec_tick ? sec_cnt_ff + 9'h1 : sec_cnt_ff;
    end
    case (state_ff)
      SAC_IDLE:
      begin
        // start only on a fresh window, so a press is not undone at once
        if (win_done && (any_ff | rx_s))
        begin
          nxt_state = SAC_ALARM;
        end
      end
      SAC_ALARM:
      begin
        nxt_tone_cnt = (tone_cnt_ff == TONE_HALF_CYC - 1) ? 32'h0 : tone_cnt_ff + 32'h1;
        nxt_tone = (tone_cnt_ff == TONE_HALF_CYC - 1) ? ~tone_ff : tone_ff;
        nxt_poll_cnt = poll_tick ? 32'h0 : poll_cnt_ff + 32'h1;
        if (poll_tick && btn_s)
        begin
          nxt_state = SAC_IDLE;
          nxt_tone = 1'h0;
          nxt_sec_div = 32'h0;
          nxt_sec_cnt = 9'h0;
        end
        else if (win_done && !(any_ff | rx_s))
        begin
          nxt_state = SAC_IDLE;
          nxt_tone = 1'h0;
          nxt_sec_div = 32'h0;
          nxt_sec_cnt = 9'h0;
        end
        else if (sec_tick && (sec_cnt_ff == 9'(ALARM_S - 1)))
        begin
          nxt_state = SAC_RELAY;
          nxt_tone = 1'h0;
          nxt_sec_cnt = 9'h0;
          nxt_relay = 1'h1;
        end
      end
      SAC_RELAY:
      begin
        nxt_relay = 1'h1;
        if (sec_tick && (sec_cnt_ff == 9'(RELAY_S - 1)))
        begin
          nxt_state = SAC_IDLE;
          nxt_relay = 1'h0;
          nxt_sec_div = 32'h0;
          nxt_sec_cnt = 9'h0;
        end
      end
      default:
      begin
        nxt_state = SAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      rx_sync_ff <= 2'h0;
      btn_sync_ff <= 2'h0;
      state_ff <= SAC_IDLE;
      smp_cnt_ff <= 32'h0;
      smp_idx_ff <= 4'h0;
      any_ff <= 1'h0;
      heat_ff <= 1'h0;
      tone_cnt_ff <= 32'h0;
      tone_ff <= 1'h0;
      poll_cnt_ff <= 32'h0;
      sec_div_ff <= 32'h0;
      sec_cnt_ff <= 9'h0;
      relay_ff <= `SAC_RELAY_RST;
    end
    else
    begin
      rx_sync_ff <= {rx_sync_ff[0], rx_i};
      btn_sync_ff <= {btn_sync_ff[0], btn_i};
      state_ff <= nxt_state;
      smp_cnt_ff <= nxt_smp_cnt;
      smp_idx_ff <= nxt_smp_idx;
      any_ff <= nxt_any;
      heat_ff <= nxt_heat;
      tone_cnt_ff <= nxt_tone_cnt;
      tone_ff <= nxt_tone;
      poll_cnt_ff <= nxt_poll_cnt;
      sec_div_ff <= nxt_sec_div;
      sec_cnt_ff <= nxt_sec_cnt;
      relay_ff <= nxt_relay;
    end
  end

  // ==========================================
  // outputs: one flop feeds all three speaker pins so they never skew
  assign drive_o = {{3{tone_ff}}, relay_ff};
  assign alarm_o = (state_ff == SAC_ALARM);

  // ==========================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_window_ten_samples: assert property (win_done |=> smp_idx_ff == 4'h0
    && any_ff == 1'h0 && smp_cnt_ff == 32'h0)
    else $error("window did not restart after its tenth sample");
  a_heat_any_one: assert property (win_done |=> heat_ff == ($past(any_ff) | $past(rx_s)))
    else $error("heat decision not the or of the samples");
  a_silent_off_alarm: assert property (state_ff != SAC_ALARM |-> drive_o.spk == `SAC_SPK_RST)
    else $error("tone outside alarm");
  a_tone_half_period: assert property ($changed(tone_ff) && state_ff == SAC_ALARM
    && $past(state_ff) == SAC_ALARM |-> $past(tone_cnt_ff) == TONE_HALF_CYC - 1)
    else $error("tone toggled off its half period");
  a_spk_in_phase: assert property (drive_o.spk == 3'h0 || drive_o.spk == 3'h7)
    else $error("speaker pins out of phase");
  a_poll_spacing: assert property (state_ff == SAC_ALARM |-> poll_cnt_ff < POLL_CYC
    && poll_cnt_ff == (($past(state_ff) != SAC_ALARM || $past(poll_tick)) ? 32'h0 : $past(poll_cnt_ff) + 32'h1))
    else $error("button poll counter off its interval");
  a_press_silences: assert property (poll_tick && btn_s |=> state_ff == SAC_IDLE && !relay_ff
    && sec_cnt_ff == 9'h0 ##1 drive_o.spk == 3'h0)
    else $error("press did not silence alarm");
  a_relay_after_alarm: assert property ($rose(relay_ff) |-> $past(state_ff) == SAC_ALARM
    && $past(sec_cnt_ff) == 9'(ALARM_S - 1))
    else $error("relay rose without full alarm time");
  a_relay_pulse_len: assert property ($fell(relay_ff) |-> $past(sec_cnt_ff) == 9'(RELAY_S - 1)
    && $past(sec_tick))
    else $error("relay pulse wrong length");
  a_back_to_idle: assert property ($fell(relay_ff) |-> state_ff == SAC_IDLE && sec_cnt_ff == 9'h0
    && tone_ff == 1'h0)
    else $error("not idle after relay pulse");

  c_alarm_start: cover property (state_ff == SAC_IDLE ##1 state_ff == SAC_ALARM);
  c_press: cover property (poll_tick && btn_s);
  c_relay: cover property ($rose(relay_ff));
  c_heat_gone: cover property (state_ff == SAC_ALARM && win_done && !(any_ff | rx_s));

endmodule : sac_ctrl
`default_nettype wire

//--- verilog/sac_defs.svh
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
// ==========================================
// timing figures, in their own units
`define SAC_CLK_HZ 20000000
`define SAC_XTAL_HZ 14745600
`define SAC_SAMPLES 10
`define SAC_SAMPLE_MS 20
`define SAC_TONE_HZ 851
`define SAC_POLL_US 1702
`define SAC_ALARM_S 300
`define SAC_RELAY_S 2
// ==========================================
// reset values
`define SAC_SPK_RST 3'h0
`define SAC_RELAY_RST 1'h0
`endif

//--- verilog/sac_pkg.sv
package sac_pkg;
  // ==========================================
  // controller states, gray along idle, alarm, relay
  typedef enum logic [1:0]
  {
    SAC_IDLE = 2'h0,
    SAC_ALARM = 2'h1,
    SAC_RELAY = 2'h3
  } sac_state_t;

  // ==========================================
  // outputs toward speaker and relay driver
  typedef struct packed
  {
    logic [2:0] spk;
    logic relay;
  } sac_out_t;
endpackage : sac_pkg
